// ### ccm_pkg.sv
// Constants, register map and carrier types of the colour correction matrix.
// Assumes component widths of at most COMP_W bits on both stream ports.
package ccm_pkg;

  localparam int COMP_W     = 16;
  localparam int COEFF_W    = 18;
  localparam int COEFF_FRAC = 15;
  localparam int OFFS_W     = COMP_W + 1;
  localparam int DIM_W      = 13;
  localparam int ACC_W      = 48;
  localparam int ADDR_W     = 12;
  localparam int NUM_CH     = 3;
  localparam int NUM_COEFF  = 9;
  localparam int WORD_BYTES = 4;

  localparam logic [ADDR_W-1:0] REG_CONTROL     = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 12'h004;
  localparam logic [ADDR_W-1:0] REG_SIZE        = 12'h008;
  localparam logic [ADDR_W-1:0] REG_COEFF_BASE  = 12'h100;
  localparam logic [ADDR_W-1:0] REG_OFFSET_BASE = 12'h124;
  localparam logic [ADDR_W-1:0] REG_CLIP        = 12'h130;
  localparam logic [ADDR_W-1:0] REG_CLAMP       = 12'h134;

  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_SWRESET_BIT = 1;
  localparam int SIZE_W_LSB       = 0;
  localparam int SIZE_H_LSB       = 16;
  localparam int ERR_EOL_EARLY    = 0;
  localparam int ERR_EOL_LATE     = 1;
  localparam int ERR_SOF_EARLY    = 2;
  localparam int ERR_SOF_LATE     = 3;
  localparam int ERR_W            = 4;

  localparam logic [1:0]         RESP_OKAY   = 2'h0;
  localparam logic [1:0]         RESP_SLVERR = 2'h2;
  localparam logic [COEFF_W-1:0] COEFF_ONE   = 18'h08000;
  localparam logic [COEFF_W-1:0] COEFF_ZERO  = 18'h00000;

  typedef logic [COMP_W-1:0] comp_t;

  typedef struct packed {
    comp_t [NUM_CH-1:0] ch;                // 0 red, 1 green, 2 blue
  } pixel_t;

  typedef struct packed {
    pixel_t data;
    logic   sof;
    logic   line_end_marker;
  } beat_t;

  typedef struct packed {
    logic [NUM_COEFF-1:0][COEFF_W-1:0] coeff;  // row-major, index 3*row+col
    logic [NUM_CH-1:0][OFFS_W-1:0]     offset; // red, green, blue channel offset
    comp_t                             clip;
    comp_t                             clamp;
    logic [DIM_W-1:0]                  width;
    logic [DIM_W-1:0]                  height;
  } config_t;

endpackage

// ### color_correction_matrix.sv
// Colour correction matrix: 3x3 weighting plus offset per pixel, framing checks.
// Assumes stream_clk_en comes from logic on sys_clk; stream_rstn comes from a pin.
//
// Behaviour
// - Output channel is weighted sum plus offset
// - Rescale result by power-of-two width ratio
// - Stream slave in, stream master out, optional control
// - Stream ports and processing share one clock
// - Control port separated, crossings synchronised
// - Register accesses complete while control enable high
// - Stream enable low freezes stream logic instantly
// - Control enable low stalls only control port
// - Stream reset clears stream logic, keeps registers
// - Control reset clears the whole device
// - Software reset and enable bits
// - Unfinished access answers with error code 10
// - Registers unreachable while stream reset or stalled
// - Flag early or late frame and line markers
// - Early frame start restarts output frame now
// - Late frame start: drop until input start
// - Early line end ends output line now
// - Late line end: emit, drop until input end
// - Without control port, build-time configuration
// - Coefficients 18-bit signed, 15 fraction bits
// - Offset signed, one bit wider than output
// - Components above upper limit take the limit
// - Components below lower limit and not above upper limit take the lower limit
`timescale 1ns/1ps

module color_correction_matrix #(
  parameter int                      IN_W       = 8,
  parameter int                      OUT_W      = 8,
  parameter bit                      HAS_CTRL   = 1'b1,
  parameter logic [ccm_pkg::DIM_W-1:0] DEF_WIDTH  = 13'h0280,
  parameter logic [ccm_pkg::DIM_W-1:0] DEF_HEIGHT = 13'h01e0
) (
  input  wire logic                        sys_clk,              // Clock, 100 MHz
  input  wire logic                        rstn,                 // Control reset, whole device
  input  wire logic                        stream_rstn,          // Stream reset pin, active low
  input  wire logic                        stream_clk_en,        // Stream clock enable
  input  wire logic                        control_clock_enable, // Control port clock enable
  input  wire logic [ccm_pkg::ADDR_W-1:0]  reg_addr,             // Register byte address
  input  wire logic [31:0]                 reg_wdata,            // Write data
  input  wire logic                        reg_we,               // Write strobe
  input  wire logic                        reg_re,               // Read strobe
  output logic      [31:0]                 reg_rdata,            // Read data, cycle after strobe
  output logic      [1:0]                  reg_resp,             // Response code, cycle after strobe
  input  wire logic                        s_valid,              // Input pixel valid
  output logic                             s_ready,              // Input pixel ready
  input  wire ccm_pkg::pixel_t             s_data,               // Input pixel
  input  wire logic                        s_sof,                // Input frame start marker
  input  wire logic                        s_eol,                // Input line end marker
  output logic                             m_valid,              // Output pixel valid
  input  wire logic                        m_ready,              // Output pixel ready
  output ccm_pkg::pixel_t                  m_data,               // Output pixel
  output logic                             m_sof,                // Output frame start marker
  output logic                             m_eol                 // Output line end marker
);

  localparam int SH = ccm_pkg::COEFF_FRAC + IN_W - OUT_W;
  localparam ccm_pkg::comp_t COMP_MASK = ccm_pkg::comp_t'((1 << OUT_W) - 1);

  localparam ccm_pkg::config_t DEF_CFG = '{
    coeff:  {ccm_pkg::COEFF_ONE, ccm_pkg::COEFF_ZERO, ccm_pkg::COEFF_ZERO,
             ccm_pkg::COEFF_ZERO, ccm_pkg::COEFF_ONE, ccm_pkg::COEFF_ZERO,
             ccm_pkg::COEFF_ZERO, ccm_pkg::COEFF_ZERO, ccm_pkg::COEFF_ONE},
    offset: '0,
    clip:   COMP_MASK,
    clamp:  '0,
    width:  DEF_WIDTH,
    height: DEF_HEIGHT
  };

  typedef struct packed {
    logic                       rst_meta;
    logic                       rst_sync;
    ccm_pkg::config_t           cfg;
    logic                       enable;
    logic                       sw_reset;
    logic [ccm_pkg::ERR_W-1:0]  err;
    logic [ccm_pkg::DIM_W-1:0]  col;
    logic [ccm_pkg::DIM_W-1:0]  row;
    logic                       wait_sof;
    logic                       wait_eol;
    logic                       out_valid;
    ccm_pkg::beat_t             out;
    logic [31:0]                rdata;
    logic [1:0]                 resp;
  } state_t;

  localparam state_t RESET_STATE = '{
    rst_meta: 1'b0, rst_sync: 1'b0, cfg: DEF_CFG, enable: 1'b1, sw_reset: 1'b0,
    err: '0, col: '0, row: '0, wait_sof: 1'b0, wait_eol: 1'b0, out_valid: 1'b0,
    out: '0, rdata: '0, resp: ccm_pkg::RESP_OKAY
  };

  state_t          st;
  state_t          next_st;
  ccm_pkg::pixel_t corrected;
  logic            stream_reset;
  logic            run;
  logic            reachable;
  logic            accept;
  logic            at_start;
  logic            line_last;

  assign stream_reset = !st.rst_sync || st.sw_reset;
  assign run          = stream_clk_en && st.enable && !stream_reset;
  assign reachable    = st.rst_sync && stream_clk_en;
  assign s_ready      = run && (!st.out_valid || m_ready);
  assign m_valid      = st.out_valid && run;
  assign accept       = s_valid && s_ready;
  assign at_start     = (st.col == '0) && (st.row == '0);
  assign line_last    = st.col == st.cfg.width - 1'b1;

  assign m_data    = st.out.data;
  assign m_sof     = st.out.sof;
  assign m_eol     = st.out.line_end_marker;
  assign reg_rdata = st.rdata;
  assign reg_resp  = st.resp;

  // Per channel datapath
  genvar ch;
  generate
    for (ch = 0; ch < ccm_pkg::NUM_CH; ch++) begin : g_chan
      logic signed [ccm_pkg::ACC_W-1:0] acc;
      logic signed [ccm_pkg::ACC_W-1:0] scaled;
      logic signed [ccm_pkg::ACC_W-1:0] term [ccm_pkg::NUM_CH];
      logic signed [ccm_pkg::ACC_W-1:0] offs;
      for (genvar k = 0; k < ccm_pkg::NUM_CH; k++) begin : g_term
        assign term[k] = ccm_pkg::ACC_W'($signed(st.cfg.coeff[ccm_pkg::NUM_CH*ch+k]))
                       * ccm_pkg::ACC_W'($signed({1'b0, s_data.ch[k][IN_W-1:0]}));
      end
      assign offs   = ccm_pkg::ACC_W'($signed(st.cfg.offset[ch])) <<< SH;
      assign acc    = term[0] + term[1] + term[2] + offs;
      assign scaled = acc >>> SH;
      // One process per channel drives its own limited value
      ccm_pkg::comp_t lim;
      // Upper limit tested first, so with a crossed pair values above it take the upper limit
      always_comb begin
        if (scaled > $signed({32'h0, st.cfg.clip})) begin
          lim = st.cfg.clip;
        end else if (scaled < $signed({32'h0, st.cfg.clamp})) begin
          lim = st.cfg.clamp;
        end else begin
          lim = scaled[ccm_pkg::COMP_W-1:0];
        end
      end
      assign corrected.ch[ch] = lim;
    end
  endgenerate

  always_comb begin
    logic [ccm_pkg::ERR_W-1:0] err_set;
    logic [ccm_pkg::ERR_W-1:0] err_clr;
    logic [ccm_pkg::DIM_W-1:0] col_v;
    logic [ccm_pkg::DIM_W-1:0] row_v;
    logic                      keep;
    logic                      sof_o;
    logic                      eol_o;
    err_set = '0;
    err_clr = '0;
    col_v   = st.col;
    row_v   = st.row;
    keep    = 1'b1;
    sof_o   = 1'b0;
    eol_o   = 1'b0;
    next_st = st;
    next_st.rst_meta = stream_rstn;
    next_st.rst_sync = st.rst_meta;

    // Control port: answers every strobe taken with control enable high in the next cycle
    if (control_clock_enable) begin
      if (reg_we || reg_re) begin
        next_st.resp = reachable ? ccm_pkg::RESP_OKAY : ccm_pkg::RESP_SLVERR;
      end
      if (reg_re) begin
        next_st.rdata = '0;
        unique case (reg_addr)
          ccm_pkg::REG_CONTROL: begin
            next_st.rdata[ccm_pkg::CTRL_ENABLE_BIT]  = st.enable;
            next_st.rdata[ccm_pkg::CTRL_SWRESET_BIT] = st.sw_reset;
          end
          ccm_pkg::REG_STATUS: next_st.rdata = 32'(st.err);
          ccm_pkg::REG_SIZE: begin
            next_st.rdata[ccm_pkg::SIZE_W_LSB +: ccm_pkg::DIM_W] = st.cfg.width;
            next_st.rdata[ccm_pkg::SIZE_H_LSB +: ccm_pkg::DIM_W] = st.cfg.height;
          end
          ccm_pkg::REG_CLIP:  next_st.rdata = 32'(st.cfg.clip);
          ccm_pkg::REG_CLAMP: next_st.rdata = 32'(st.cfg.clamp);
          default: begin
            for (int i = 0; i < ccm_pkg::NUM_COEFF; i++) begin
              if (reg_addr == ccm_pkg::ADDR_W'(ccm_pkg::REG_COEFF_BASE + ccm_pkg::WORD_BYTES*i)) begin
                next_st.rdata = 32'(st.cfg.coeff[i]);
              end
            end
            for (int i = 0; i < ccm_pkg::NUM_CH; i++) begin
              if (reg_addr == ccm_pkg::ADDR_W'(ccm_pkg::REG_OFFSET_BASE + ccm_pkg::WORD_BYTES*i)) begin
                next_st.rdata = 32'(st.cfg.offset[i]);
              end
            end
          end
        endcase
      end
      if (reg_we && reachable && reg_addr == ccm_pkg::REG_STATUS) begin
        err_clr = reg_wdata[ccm_pkg::ERR_W-1:0];
      end
      if (reg_we && reachable && HAS_CTRL) begin
        unique case (reg_addr)
          ccm_pkg::REG_CONTROL: begin
            next_st.enable   = reg_wdata[ccm_pkg::CTRL_ENABLE_BIT];
            next_st.sw_reset = reg_wdata[ccm_pkg::CTRL_SWRESET_BIT];
          end
          ccm_pkg::REG_SIZE: begin
            next_st.cfg.width  = reg_wdata[ccm_pkg::SIZE_W_LSB +: ccm_pkg::DIM_W];
            next_st.cfg.height = reg_wdata[ccm_pkg::SIZE_H_LSB +: ccm_pkg::DIM_W];
          end
          ccm_pkg::REG_CLIP:  next_st.cfg.clip  = reg_wdata[ccm_pkg::COMP_W-1:0] & COMP_MASK;
          ccm_pkg::REG_CLAMP: next_st.cfg.clamp = reg_wdata[ccm_pkg::COMP_W-1:0] & COMP_MASK;
          default: begin
            for (int i = 0; i < ccm_pkg::NUM_COEFF; i++) begin
              if (reg_addr == ccm_pkg::ADDR_W'(ccm_pkg::REG_COEFF_BASE + ccm_pkg::WORD_BYTES*i)) begin
                next_st.cfg.coeff[i] = reg_wdata[ccm_pkg::COEFF_W-1:0];
              end
            end
            for (int i = 0; i < ccm_pkg::NUM_CH; i++) begin
              if (reg_addr == ccm_pkg::ADDR_W'(ccm_pkg::REG_OFFSET_BASE + ccm_pkg::WORD_BYTES*i)) begin
                // Offset is signed at output width plus one: extend its sign bit
                next_st.cfg.offset[i] = ccm_pkg::OFFS_W'($signed(reg_wdata[OUT_W:0]));
              end
            end
          end
        endcase
      end
    end

    // Stream side: cleared under stream reset, else frozen whenever run is low
    if (stream_reset) begin
      next_st.col       = '0;
      next_st.row       = '0;
      next_st.wait_sof  = 1'b0;
      next_st.wait_eol  = 1'b0;
      next_st.out_valid = 1'b0;
    end else if (run) begin
      if (m_ready) begin
        next_st.out_valid = 1'b0;
      end
      if (accept) begin
        if (st.wait_sof) begin
          keep = s_sof;
          next_st.wait_sof = !s_sof;
        end else if (st.wait_eol) begin
          keep = 1'b0;
          next_st.wait_eol = !s_eol;
        end else if (s_sof && !at_start) begin
          err_set[ccm_pkg::ERR_SOF_EARLY] = 1'b1;
          col_v = '0;
          row_v = '0;
        end else if (!s_sof && at_start) begin
          err_set[ccm_pkg::ERR_SOF_LATE] = 1'b1;
          keep = 1'b0;
          next_st.wait_sof = 1'b1;
        end
        if (keep) begin
          sof_o = (col_v == '0) && (row_v == '0);
          eol_o = s_eol || (col_v == st.cfg.width - 1'b1);
          if (s_eol && col_v != st.cfg.width - 1'b1) begin
            err_set[ccm_pkg::ERR_EOL_EARLY] = 1'b1;
          end
          if (!s_eol && col_v == st.cfg.width - 1'b1) begin
            err_set[ccm_pkg::ERR_EOL_LATE] = 1'b1;
            next_st.wait_eol = 1'b1;
          end
          if (eol_o) begin
            next_st.col = '0;
            next_st.row = (row_v == st.cfg.height - 1'b1) ? '0 : row_v + 1'b1;
          end else begin
            next_st.col = col_v + 1'b1;
            next_st.row = row_v;
          end
          next_st.out_valid = 1'b1;
          next_st.out       = '{data: corrected, sof: sof_o, line_end_marker: eol_o};
        end
      end
    end
    next_st.err = (st.err & ~err_clr) | err_set;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_hold_stall: assert property ((m_valid && !m_ready) |=> (st.out_valid && $stable(st.out)))
    else $error("output beat changed while stalled");
  a_freeze_stream: assert property ((!stream_clk_en && !stream_reset) |=>
    $stable({st.col, st.row, st.out_valid, st.out, st.wait_sof, st.wait_eol}))
    else $error("stream state moved while frozen");
  a_ctrl_stall: assert property ((!control_clock_enable) |=> ($stable(st.cfg) && $stable(st.resp)))
    else $error("control state moved while control enable low");
  a_stream_rst_clear: assert property ((!st.rst_sync) |=> (!st.out_valid && st.col == '0 && !m_valid))
    else $error("stream reset did not clear stream logic");
  a_rst_keeps_cfg: assert property ((!st.rst_sync && !reg_we) |=> $stable(st.cfg))
    else $error("stream reset disturbed configuration");
  a_unreach_err: assert property (((reg_re || reg_we) && control_clock_enable && !stream_clk_en)
    |=> reg_resp == ccm_pkg::RESP_SLVERR)
    else $error("unreachable access did not answer with error");
  a_sof_early: assert property ((accept && s_sof && !at_start && !st.wait_sof && !st.wait_eol)
    |=> (st.out_valid && st.out.sof && st.err[ccm_pkg::ERR_SOF_EARLY]))
    else $error("early frame start not passed on at once");
  a_sof_late: assert property ((accept && !s_sof && at_start && !st.wait_sof && !st.wait_eol)
    |=> (st.wait_sof && !st.out_valid))
    else $error("late frame start did not drop pixels");
  a_eol_early: assert property ((accept && s_eol && !s_sof && !line_last && !at_start
    && !st.wait_sof && !st.wait_eol) |=> (st.out.line_end_marker && st.col == '0))
    else $error("early line end not passed on at once");
  a_eol_late: assert property ((accept && !s_eol && !s_sof && line_last && !at_start
    && !st.wait_sof && !st.wait_eol) |=> (st.out.line_end_marker && st.wait_eol))
    else $error("late line end not emitted at programmed length");
  a_limit_red: assert property ((m_valid && st.cfg.clip >= st.cfg.clamp && $stable(st.cfg))
    |-> (m_data.ch[0] <= st.cfg.clip && m_data.ch[0] >= st.cfg.clamp))
    else $error("red component outside limits");
  a_err_sticky: assert property ((st.err[ccm_pkg::ERR_EOL_EARLY] && !(reg_we && reg_addr == ccm_pkg::REG_STATUS))
    |=> st.err[ccm_pkg::ERR_EOL_EARLY])
    else $error("error flag lost without clear");

  c_sof_early: cover property (accept && s_sof && !at_start && !st.wait_sof && !st.wait_eol);
  c_eol_late: cover property (st.err[ccm_pkg::ERR_EOL_LATE] && st.wait_eol);
  c_stall: cover property (m_valid && !m_ready ##1 m_valid && m_ready);
  c_unreach: cover property (reg_re && !stream_clk_en ##1 reg_resp == ccm_pkg::RESP_SLVERR);

endmodule

// ### stream_sink.sv
// Downstream sink model of the output stream: takes pixels promptly or with random stalls.
// Assumes the bench checks every beat that this sink accepts.
`timescale 1ns/1ps

module stream_sink (
  input  wire logic sys_clk, // Clock
  input  wire logic slow,    // Stall at random while high
  output logic      m_ready  // Ready toward the block
);
  initial m_ready = 1'b0;

  // Ready may drop in any cycle while slow is high, as a real downstream core may do
  always @(posedge sys_clk) begin
    m_ready <= slow ? 1'($urandom % 2) : 1'b1;
  end
endmodule

// ### color_correction_matrix_tb.sv
// Self-checking bench of the colour correction matrix, with an integer model of the pixel math.
// Assumes stream_sink.sv and the design package are compiled first.
`timescale 1ns/1ps

module color_correction_matrix_tb;
  localparam int SH = 13;
  logic                       sys_clk, rstn, stream_rstn, stream_clk_en, control_clock_enable;
  logic                       reg_we, reg_re, s_valid, s_ready, s_sof, s_eol, m_valid, m_ready, m_sof, m_eol;
  logic                       slow, en_rand;
  logic [ccm_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0]                reg_wdata, reg_rdata, rdv;
  logic [1:0]                 reg_resp, rs;
  ccm_pkg::pixel_t            s_data, m_data;
  ccm_pkg::beat_t             exp_q[$];
  longint                     k[9], off[3], clip, clamp;
  int                         n_mismatch, n_compared;
  int                         cyc = 0;

  color_correction_matrix #(.IN_W(8), .OUT_W(10), .DEF_WIDTH(13'h0004), .DEF_HEIGHT(13'h0002))
    color_correction_matrix_i (.sys_clk, .rstn, .stream_rstn, .stream_clk_en, .control_clock_enable,
    .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .reg_resp, .s_valid, .s_ready, .s_data,
    .s_sof, .s_eol, .m_valid, .m_ready, .m_data, .m_sof, .m_eol);
  stream_sink stream_sink_i (.sys_clk, .slow, .m_ready);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (en_rand) stream_clk_en <= ($urandom % 4) != 0;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk_val(logic [33:0] got, logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_beat(ccm_pkg::beat_t got, ccm_pkg::beat_t exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic ccm_pkg::pixel_t calc(ccm_pkg::pixel_t p);
    ccm_pkg::pixel_t r;
    longint          v;
    r = '0;
    for (int c = 0; c < 3; c++) begin
      v = off[c] <<< SH;
      for (int j = 0; j < 3; j++) v += k[3*c+j] * longint'(p.ch[j][7:0]);
      v = v >>> SH;
      if (v > clip) v = clip;
      if (v < clamp) v = clamp;
      r.ch[c] = 16'(v);
    end
    return r;
  endfunction

  task automatic reg_wr(logic [11:0] a, logic [31:0] d, logic ce = 1'b1);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    control_clock_enable <= ce;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    control_clock_enable <= 1'b1;
    #1 rs = reg_resp;
  endtask

  task automatic reg_rd(logic [11:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 rdv = reg_rdata;
    rs = reg_resp;
  endtask

  task automatic rc(logic [11:0] a, logic [31:0] d);
    reg_rd(a);
    chk_val({rs, rdv}, {ccm_pkg::RESP_OKAY, d});
  endtask

  task automatic send(logic sof, logic line_end_marker, logic keep, logic osof, logic oeol);
    ccm_pkg::pixel_t p;
    p = 48'({$urandom, $urandom});
    s_valid <= 1'b1;
    s_data <= p;
    s_sof <= sof;
    s_eol <= line_end_marker;
    do @(posedge sys_clk); while (s_ready !== 1'b1);
    if (keep) exp_q.push_back(ccm_pkg::beat_t'{data: calc(p), sof: osof, line_end_marker: oeol});
  endtask

  task automatic drain();
    s_valid <= 1'b0;
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge sys_clk);
    #1 chk_val(34'(exp_q.size()), 34'h0);
  endtask

  task automatic frame();
    for (int i = 0; i < 8; i++) send(i == 0, i % 4 == 3, 1'b1, i == 0, i % 4 == 3);
    drain();
  endtask

  task automatic cfg_rand();
    logic [31:0] w;
    for (int i = 0; i < 9; i++) begin
      w = ($urandom & 32'hffff) - 32'h8000;
      k[i] = $signed(w[17:0]);
      reg_wr(ccm_pkg::REG_COEFF_BASE + 12'(4 * i), w);
    end
    for (int c = 0; c < 3; c++) begin
      w = $urandom & 32'h7ff;
      off[c] = $signed(w[10:0]);
      reg_wr(ccm_pkg::REG_OFFSET_BASE + 12'(4 * c), w);
    end
    clip = 32'h200 + ($urandom & 32'h1ff);
    clamp = $urandom & 32'hff;
    reg_wr(ccm_pkg::REG_CLIP, 32'(clip));
    reg_wr(ccm_pkg::REG_CLAMP, 32'(clamp));
  endtask

  task automatic defaults();
    k = '{32768, 0, 0, 0, 32768, 0, 0, 0, 32768};
    off = '{0, 0, 0};
    clip = 'h3ff;
    clamp = 0;
  endtask

  always @(posedge sys_clk) begin
    if (m_valid === 1'b1 && m_ready === 1'b1) begin
      if (exp_q.size() == 0) chk_val(34'h1, 34'h0);
      else chk_beat({m_data, m_sof, m_eol}, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(27));
    {rstn, reg_we, reg_re, s_valid, s_sof, s_eol, slow, en_rand} = '0;
    {stream_rstn, stream_clk_en, control_clock_enable} = 3'h7;
    reg_addr = '0;
    reg_wdata = '0;
    s_data = '0;
    defaults();
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    // Registers answer only once the stream reset synchroniser has released
    repeat (2) @(posedge sys_clk);
    rc(ccm_pkg::REG_CONTROL, 32'h1);
    rc(ccm_pkg::REG_SIZE, 32'h0002_0004);
    rc(ccm_pkg::REG_COEFF_BASE, 32'h0000_8000);
    rc(ccm_pkg::REG_CLIP, 32'h3ff);
    rc(12'h0ff, 32'h0);
    frame();
    $display("test reset values and scaling done");
    cfg_rand();
    slow = 1'b1;
    en_rand = 1'b1;
    repeat (3) frame();
    en_rand = 1'b0;
    stream_clk_en <= 1'b1;
    $display("test random frames done");
    send(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    send(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) send(1'b0, i == 4, i < 4, 1'b0, i == 3);
    drain();
    rc(ccm_pkg::REG_STATUS, 32'h3);
    reg_wr(ccm_pkg::REG_STATUS, 32'hf);
    rc(ccm_pkg::REG_STATUS, 32'h0);
    send(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    frame();
    reg_rd(ccm_pkg::REG_STATUS);
    chk_val(34'(rdv & 32'h4), 34'h4);
    $display("test line and frame errors done");
    reg_wr(ccm_pkg::REG_CLAMP, 32'h5, 1'b0);
    rc(ccm_pkg::REG_CLAMP, 32'(clamp));
    stream_clk_en <= 1'b0;
    reg_wr(ccm_pkg::REG_CLAMP, 32'h5);
    chk_val({rs, 1'b0, s_ready, m_valid, 29'h0}, {ccm_pkg::RESP_SLVERR, 32'h0});
    stream_clk_en <= 1'b1;
    stream_rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reg_rd(ccm_pkg::REG_CLIP);
    chk_val({rs, rdv}, {ccm_pkg::RESP_SLVERR, 32'(clip)});
    reg_wr(ccm_pkg::REG_CLAMP, 32'h7);
    repeat (32) @(posedge sys_clk);
    stream_rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rc(ccm_pkg::REG_CLAMP, 32'(clamp));
    send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    frame();
    reg_rd(ccm_pkg::REG_STATUS);
    chk_val(34'(rdv & 32'h8), 34'h8);
    $display("test enables and stream reset done");
    reg_wr(ccm_pkg::REG_CONTROL, 32'h0);
    rc(ccm_pkg::REG_CONTROL, 32'h0);
    chk_val(34'(s_ready), 34'h0);
    reg_wr(ccm_pkg::REG_CONTROL, 32'h1);
    reg_wr(ccm_pkg::REG_CONTROL, 32'h3);
    chk_val({rs, 31'h0, s_ready}, {ccm_pkg::RESP_OKAY, 32'h0});
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    defaults();
    rc(ccm_pkg::REG_CLAMP, 32'h0);
    frame();
    $display("test software and control reset done");
    summarize();
  end
endmodule
